// file: common/scc_pkg.sv
/*
 * Shared constants for the serial channel control block: register offsets,
 * control field positions, reset value and counter widths.
 * Assumes byte addressing on the host I/O port with one 32-bit word per register.
 */
package scc_pkg;
    localparam int SCC_ADDR_W = 6;
    localparam int SCC_CNT_W = 16;
    localparam int SCC_PADDR_W = 16;
    localparam int SCC_OFF_W = 3;

    localparam logic [5:0] SCC_CTRL_OFS = 6'h20;
    localparam logic [5:0] SCC_PLAY1_CNT_OFS = 6'h24;
    localparam logic [5:0] SCC_PLAY2_CNT_OFS = 6'h28;
    localparam logic [5:0] SCC_REC_CNT_OFS = 6'h2C;

    localparam logic [31:0] SCC_CTRL_RST = 32'hFF800000;
    localparam logic [8:0] SCC_CTRL_ONES = 9'h1FF;
    localparam int SCC_CTRL_STORE_W = 23;

    localparam int SCC_TEST_CLK_BIT = 22;
    localparam int SCC_END_OFS_LSB = 19;
    localparam int SCC_ST_OFS_LSB = 16;
    localparam int SCC_REC_STOP_BIT = 15;
    localparam int SCC_P2_STOP_BIT = 14;
    localparam int SCC_P1_STOP_BIT = 13;
    localparam int SCC_P2_HOLD_BIT = 12;
    localparam int SCC_P1_HOLD_BIT = 11;

    localparam logic [15:0] SCC_CNT_RST = 16'h0000;
endpackage

// file: common/scc_cnt_if.sv
/*
 * Bundle between the control logic and one channel sample counter.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface scc_cnt_if;
    logic [15:0] preset;
    logic start;
    logic tick;
    logic run;
    logic stop_sel;
    logic [15:0] live;
    logic zero;
    logic stopped;

    modport ctl (output preset, start, tick, run, stop_sel, input live, zero, stopped);
    modport cnt (input preset, start, tick, run, stop_sel, output live, zero, stopped);
endinterface
`default_nettype wire

// file: rtl/scc_counter.sv
/*
 * One channel sample counter: loads the preset on start, counts down once per
 * sample period, flags the zero crossing and then reloads or stops.
 * Assumes tick is a one-cycle pulse in the system clock domain.
 */
`timescale 1ns/1ps
`default_nettype none
module scc_counter (
    input wire logic sys_clk_i, // System clock
    input wire logic nrst_i,    // Async reset, active low
    scc_cnt_if.cnt ch           // Counter bundle
);
    import scc_pkg::*;

    logic [15:0] live_q;
    logic [15:0] live_d;
    logic stopped_q;
    logic stopped_d;
    logic zero_q;
    logic zero_d;
    wire count_step = ch.tick && ch.run && !stopped_q;
    wire at_zero = (live_q == 16'h0000);

    always_comb begin
        live_d = live_q;
        stopped_d = stopped_q;
        zero_d = 1'b0;
        if (ch.start) begin
            live_d = ch.preset;
            stopped_d = 1'b0;
        end else if (count_step) begin
            if (at_zero) begin
                zero_d = 1'b1;
                if (ch.stop_sel) begin
                    stopped_d = 1'b1;
                end else begin
                    live_d = ch.preset;
                end
            end else begin
                live_d = live_q - 16'h0001;
            end
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            live_q <= SCC_CNT_RST;
            stopped_q <= 1'b0;
            zero_q <= 1'b0;
        end else begin
            live_q <= live_d;
            stopped_q <= stopped_d;
            zero_q <= zero_d;
        end
    end

    assign ch.live = live_q;
    assign ch.zero = zero_q;
    assign ch.stopped = stopped_q;
endmodule
`default_nettype wire

// file: rtl/scc_top.sv
/*
 * Serial channel control: control register, three sample count registers,
 * frame clock selection, loop/stop and hold handling for two playback channels
 * and one record channel, and the playback 2 sample address counter.
 * Assumes frame clocks arrive asynchronously from the codec side and that
 * channel enables and the address step come from same-clock logic.
 */
// Notes on behaviour
// - Count registers accept writes in low half only
// - Count register upper half reads live counter
// - Control bits 31:23 read one, unwritable
// - Control resets to FF800000, byte/word/long writes
// - Test bit selects input frame clock everywhere
// - Loop end adds end offset to address
// - Start or restart loads start offset
// - Record count zero: flag, then loop or stop
// - Playback 2 count zero: flag, loop or hold
// - Playback 1 count zero: flag, loop or hold
// - Playback 2 hold repeats last sample per period
// - Bit 11 holds playback 1
// - Playback 1 hold acts on sample boundaries
// - Preset is samples minus one, counted down
`timescale 1ns/1ps
`default_nettype none
module scc_top (
    input wire logic sys_clk_i,                  // System clock, 50 MHz
    input wire logic nrst_i,                     // Async reset, active low
    input wire logic [scc_pkg::SCC_ADDR_W-1:0] reg_addr_i, // Byte address
    input wire logic reg_wr_i,                   // Write strobe
    input wire logic [3:0] reg_be_i,             // Byte enables
    input wire logic [31:0] reg_wdata_i,         // Write data
    input wire logic reg_rd_i,                   // Read strobe
    output logic [31:0] reg_rdata_o,             // Read data, valid cycle after strobe
    input wire logic play1_frame_i,              // Playback 1 frame clock pin
    input wire logic play2_frame_i,              // Playback 2 frame clock pin
    input wire logic rec_frame_i,                // Record frame clock pin
    input wire logic serial_in_frame_i,          // Serial input frame clock pin
    input wire logic play1_en_i,                 // Playback 1 enable
    input wire logic play2_en_i,                 // Playback 2 enable
    input wire logic rec_en_i,                   // Record enable
    input wire logic [2:0] play2_step_i,         // Bytes per playback 2 sample
    output logic play1_advance_o,                // Playback 1 fetch next sample
    output logic play1_repeat_o,                 // Playback 1 repeats last sample
    output logic play1_zero_o,                   // Playback 1 count expired pulse
    output logic play2_advance_o,                // Playback 2 fetch next sample
    output logic play2_repeat_o,                 // Playback 2 repeats last sample
    output logic play2_zero_o,                   // Playback 2 count expired pulse
    output logic [scc_pkg::SCC_PADDR_W-1:0] play2_addr_o, // Playback 2 sample address
    output logic rec_capture_o,                  // Record store sample pulse
    output logic rec_active_o,                   // Record channel running
    output logic rec_zero_o                      // Record count expired pulse
);
    import scc_pkg::*;

    scc_cnt_if p1_if ();
    scc_cnt_if p2_if ();
    scc_cnt_if rc_if ();

    // Registers
    logic [SCC_CTRL_STORE_W-1:0] ctrl_q;
    logic [15:0] p1_preset_q;
    logic [15:0] p2_preset_q;
    logic [15:0] rc_preset_q;
    logic [31:0] rdata_q;

    // Pin synchronisers and edge history
    logic [3:0] frame_s1_q;
    logic [3:0] frame_s2_q;
    logic [2:0] frame_prev_q;
    logic en_prev_q;
    logic en2_prev_q;
    logic enr_prev_q;

    // Channel state
    logic p1_hold_q;
    logic p2_hold_q;
    logic [SCC_PADDR_W-1:0] p2_addr_q;
    logic [SCC_PADDR_W-1:0] p2_addr_d;
    logic p1_adv_q;
    logic p2_adv_q;
    logic rec_cap_q;

    // Register decode
    wire sel_ctrl = (reg_addr_i == SCC_CTRL_OFS);
    wire sel_p1 = (reg_addr_i == SCC_PLAY1_CNT_OFS);
    wire sel_p2 = (reg_addr_i == SCC_PLAY2_CNT_OFS);
    wire sel_rc = (reg_addr_i == SCC_REC_CNT_OFS);
    wire wr_ctrl = reg_wr_i && sel_ctrl;
    wire wr_p1 = reg_wr_i && sel_p1;
    wire wr_p2 = reg_wr_i && sel_p2;
    wire wr_rc = reg_wr_i && sel_rc;

    // Control fields
    wire test_clk = ctrl_q[SCC_TEST_CLK_BIT];
    wire [2:0] end_ofs = ctrl_q[SCC_END_OFS_LSB +: SCC_OFF_W];
    wire [2:0] st_ofs = ctrl_q[SCC_ST_OFS_LSB +: SCC_OFF_W];
    wire rec_stop_sel = ctrl_q[SCC_REC_STOP_BIT];
    wire p2_stop_sel = ctrl_q[SCC_P2_STOP_BIT];
    wire p1_stop_sel = ctrl_q[SCC_P1_STOP_BIT];
    wire p2_hold_sel = ctrl_q[SCC_P2_HOLD_BIT];
    wire p1_hold_sel = ctrl_q[SCC_P1_HOLD_BIT];

    // Merged write data, byte lanes applied
    wire [7:0] ctrl_b0 = reg_be_i[0] ? reg_wdata_i[7:0] : ctrl_q[7:0];
    wire [7:0] ctrl_b1 = reg_be_i[1] ? reg_wdata_i[15:8] : ctrl_q[15:8];
    wire [6:0] ctrl_b2 = reg_be_i[2] ? reg_wdata_i[22:16] : ctrl_q[22:16];
    wire [22:0] ctrl_wr_val = {ctrl_b2, ctrl_b1, ctrl_b0};

    // Read mux; unmapped offsets read as zero
    wire [31:0] ctrl_rd = {SCC_CTRL_ONES, ctrl_q};
    wire [31:0] p1_rd = {p1_if.live, p1_preset_q};
    wire [31:0] p2_rd = {p2_if.live, p2_preset_q};
    wire [31:0] rc_rd = {rc_if.live, rc_preset_q};
    wire [31:0] rd_val = sel_ctrl ? ctrl_rd :
                         sel_p1 ? p1_rd :
                         sel_p2 ? p2_rd :
                         sel_rc ? rc_rd : 32'h00000000;

    // Frame timing; the serial input clock overrides all channels in test mode
    wire [2:0] frame_sync = frame_s2_q[2:0];
    wire [2:0] frame_src = test_clk ? {3{frame_s2_q[3]}} : frame_sync;
    wire [2:0] frame_rise = frame_src & ~frame_prev_q;
    wire p1_tick = frame_rise[0];
    wire p2_tick = frame_rise[1];
    wire rc_tick = frame_rise[2];

    // Channel start on enable rising edge
    wire p1_start = play1_en_i && !en_prev_q;
    wire p2_start = play2_en_i && !en2_prev_q;
    wire rc_start = rec_en_i && !enr_prev_q;

    // Playback moves on only while neither held nor stopped; the hold bit is read
    // at the tick itself, so the first boundary after setting it already repeats
    wire p1_play = play1_en_i && !p1_hold_sel && !p1_if.stopped;
    wire p2_play = play2_en_i && !p2_hold_sel && !p2_if.stopped;
    wire rc_run = rec_en_i && !rc_if.stopped;
    wire p2_loop_end = p2_play && p2_tick && (p2_if.live == 16'h0000) && !p2_stop_sel;

    assign p1_if.preset = p1_preset_q;
    assign p1_if.start = p1_start;
    assign p1_if.tick = p1_tick;
    assign p1_if.run = p1_play;
    assign p1_if.stop_sel = p1_stop_sel;
    assign p2_if.preset = p2_preset_q;
    assign p2_if.start = p2_start;
    assign p2_if.tick = p2_tick;
    assign p2_if.run = p2_play;
    assign p2_if.stop_sel = p2_stop_sel;
    assign rc_if.preset = rc_preset_q;
    assign rc_if.start = rc_start;
    assign rc_if.tick = rc_tick;
    assign rc_if.run = rc_run;
    assign rc_if.stop_sel = rec_stop_sel;

    scc_counter u_cnt_p1 (
        .sys_clk_i (sys_clk_i),
        .nrst_i (nrst_i),
        .ch (p1_if)
    );

    scc_counter u_cnt_p2 (
        .sys_clk_i (sys_clk_i),
        .nrst_i (nrst_i),
        .ch (p2_if)
    );

    scc_counter u_cnt_rc (
        .sys_clk_i (sys_clk_i),
        .nrst_i (nrst_i),
        .ch (rc_if)
    );

    // Playback 2 address; loop end offset relies on software keeping it nonzero
    always_comb begin
        p2_addr_d = p2_addr_q;
        if (p2_start) begin
            p2_addr_d = {13'h0000, st_ofs};
        end else if (p2_loop_end) begin
            p2_addr_d = p2_addr_q + {13'h0000, end_ofs};
        end else if (p2_play && p2_tick) begin
            p2_addr_d = p2_addr_q + {13'h0000, play2_step_i};
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= SCC_CTRL_RST[SCC_CTRL_STORE_W-1:0];
        end else if (wr_ctrl) begin
            ctrl_q <= ctrl_wr_val;
        end
    end

    // Only lanes 0 and 1 reach the presets; the upper half is status
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            p1_preset_q <= SCC_CNT_RST;
            p2_preset_q <= SCC_CNT_RST;
            rc_preset_q <= SCC_CNT_RST;
        end else begin
            if (wr_p1 && reg_be_i[0]) p1_preset_q[7:0] <= reg_wdata_i[7:0];
            if (wr_p1 && reg_be_i[1]) p1_preset_q[15:8] <= reg_wdata_i[15:8];
            if (wr_p2 && reg_be_i[0]) p2_preset_q[7:0] <= reg_wdata_i[7:0];
            if (wr_p2 && reg_be_i[1]) p2_preset_q[15:8] <= reg_wdata_i[15:8];
            if (wr_rc && reg_be_i[0]) rc_preset_q[7:0] <= reg_wdata_i[7:0];
            if (wr_rc && reg_be_i[1]) rc_preset_q[15:8] <= reg_wdata_i[15:8];
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_q <= 32'h00000000;
        end else if (reg_rd_i) begin
            rdata_q <= rd_val;
        end
    end

    // Two flops per frame pin before any edge logic looks at it
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            frame_s1_q <= 4'h0;
            frame_s2_q <= 4'h0;
            frame_prev_q <= 3'h0;
        end else begin
            frame_s1_q <= {serial_in_frame_i, rec_frame_i, play2_frame_i, play1_frame_i};
            frame_s2_q <= frame_s1_q;
            frame_prev_q <= frame_src;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_prev_q <= 1'b0;
            en2_prev_q <= 1'b0;
            enr_prev_q <= 1'b0;
        end else begin
            en_prev_q <= play1_en_i;
            en2_prev_q <= play2_en_i;
            enr_prev_q <= rec_en_i;
        end
    end

    // Hold is sampled only at a sample boundary, so it never splits a sample
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            p1_hold_q <= 1'b0;
            p2_hold_q <= 1'b0;
        end else begin
            if (p1_tick) p1_hold_q <= p1_hold_sel;
            if (p2_tick) p2_hold_q <= p2_hold_sel;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            p2_addr_q <= 16'h0000;
        end else begin
            p2_addr_q <= p2_addr_d;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            p1_adv_q <= 1'b0;
            p2_adv_q <= 1'b0;
            rec_cap_q <= 1'b0;
        end else begin
            p1_adv_q <= p1_play && p1_tick;
            p2_adv_q <= p2_play && p2_tick;
            rec_cap_q <= rc_run && rc_tick;
        end
    end

    // Repeat flags and activity come from counter and hold flops
    logic p1_rep_q;
    logic p2_rep_q;
    logic rec_act_q;

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            p1_rep_q <= 1'b0;
            p2_rep_q <= 1'b0;
            rec_act_q <= 1'b0;
        end else begin
            p1_rep_q <= play1_en_i && (p1_hold_q || p1_if.stopped);
            p2_rep_q <= play2_en_i && (p2_hold_q || p2_if.stopped);
            rec_act_q <= rc_run;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign play1_advance_o = p1_adv_q;
    assign play1_repeat_o = p1_rep_q;
    assign play1_zero_o = p1_if.zero;
    assign play2_advance_o = p2_adv_q;
    assign play2_repeat_o = p2_rep_q;
    assign play2_zero_o = p2_if.zero;
    assign play2_addr_o = p2_addr_q;
    assign rec_capture_o = rec_cap_q;
    assign rec_active_o = rec_act_q;
    assign rec_zero_o = rc_if.zero;
endmodule
`default_nettype wire

// file: tb/scc_codec_model.sv
/*
 * Behavioural codec side: frame clocks for playback 1, playback 2, record
 * and the serial input. Assumes the bench asks for frames with run_i.
 */
`timescale 1ns/1ps
`default_nettype none
module scc_codec_model (
    input wire logic [3:0] run_i, // Frame request per pin
    output logic [3:0] frame_o    // Frame clocks {serial, rec, play2, play1}
);
    // Odd start offset keeps the frame edges away from the system clock edges
    initial begin
        frame_o = 4'h0;
        #7;
        // 160 ns period while running; a pin stands low between frames
        forever #80 frame_o = (frame_o ^ run_i) & run_i;
    end
endmodule
`default_nettype wire

// file: tb/scc_top_props.sv
/*
 * Port checker for scc_top: control readback, start offset, hold and
 * count-expiry behaviour. Assumes a bind to scc_top; shadows control writes.
 */
`timescale 1ns/1ps
`default_nettype none
module scc_top_props (
    input wire logic sys_clk_i, // Clock
    input wire logic nrst_i, // Reset, active low
    input wire logic [scc_pkg::SCC_ADDR_W-1:0] reg_addr_i, // Address
    input wire logic reg_wr_i, // Write strobe
    input wire logic [3:0] reg_be_i, // Byte enables
    input wire logic [31:0] reg_wdata_i, // Write data
    input wire logic reg_rd_i, // Read strobe
    input wire logic [31:0] reg_rdata_o, // Read data
    input wire logic play1_en_i, // Playback 1 enable
    input wire logic play2_en_i, // Playback 2 enable
    input wire logic rec_en_i, // Record enable
    input wire logic play1_advance_o, // Playback 1 advance
    input wire logic play1_repeat_o, // Playback 1 repeat
    input wire logic play1_zero_o, // Playback 1 expiry
    input wire logic play2_advance_o, // Playback 2 advance
    input wire logic play2_repeat_o, // Playback 2 repeat
    input wire logic play2_zero_o, // Playback 2 expiry
    input wire logic [scc_pkg::SCC_PADDR_W-1:0] play2_addr_o, // Playback 2 address
    input wire logic rec_active_o, // Record running
    input wire logic rec_zero_o // Record expiry
);
    import scc_pkg::*;
    logic [22:0] sh_q;
    wire wr_ctl = reg_wr_i && reg_addr_i == SCC_CTRL_OFS;
    wire rd_ctl = reg_rd_i && reg_addr_i == SCC_CTRL_OFS;
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sh_q <= 23'h000000;
        end else begin
            if (wr_ctl && reg_be_i[0]) sh_q[7:0] <= reg_wdata_i[7:0];
            if (wr_ctl && reg_be_i[1]) sh_q[15:8] <= reg_wdata_i[15:8];
            if (wr_ctl && reg_be_i[2]) sh_q[22:16] <= reg_wdata_i[22:16];
        end
    end
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_ones;
        rd_ctl |=> reg_rdata_o[31:23] == SCC_CTRL_ONES;
    endproperty
    a_ones: assert property (p_ones) else $error("ctrl high bits not ones");
    property p_ctrl;
        rd_ctl |=> reg_rdata_o[22:0] == $past(sh_q);
    endproperty
    a_ctrl: assert property (p_ctrl) else $error("ctrl readback wrong");
    property p_start;
        $rose(play2_en_i) |-> ##[1:2] play2_addr_o == {13'h0000, sh_q[18:16]};
    endproperty
    a_start: assert property (p_start) else $error("start offset not applied");
    // An advance pulse reflects the hold bit one cycle earlier, at its tick
    property p_hold2;
        $past(sh_q[12]) |-> !play2_advance_o;
    endproperty
    a_hold2: assert property (p_hold2) else $error("play2 advanced in hold");
    property p_hold1;
        $past(sh_q[11]) |-> !play1_advance_o;
    endproperty
    a_hold1: assert property (p_hold1) else $error("play1 advanced in hold");
    property p_stop2;
        play2_zero_o && !sh_q[12] |-> play2_advance_o
            ##[1:2] play2_repeat_o == sh_q[14];
    endproperty
    a_stop2: assert property (p_stop2) else $error("play2 expiry action wrong");
    property p_stop1;
        play1_zero_o && !sh_q[11] |-> play1_advance_o
            ##[1:2] play1_repeat_o == sh_q[13];
    endproperty
    a_stop1: assert property (p_stop1) else $error("play1 expiry action wrong");
    property p_rec;
        rec_zero_o && rec_en_i |-> ##2 rec_active_o == !sh_q[15];
    endproperty
    a_rec: assert property (p_rec) else $error("record expiry action wrong");
    c_loop2: cover property (play2_zero_o && !sh_q[14]);
    c_stop2: cover property (play2_zero_o && sh_q[14]);
    c_rec: cover property (rec_zero_o && sh_q[22]);
endmodule
bind scc_top scc_top_props u_props (.*);
`default_nettype wire

// file: tb/tb_scc_top.sv
/*
 * Self-checking bench for scc_top: registers, playback 2 addressing,
 * stop, hold, test clock and record. Assumes the codec model drives frames.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_scc_top;
    import scc_pkg::*;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [5:0] reg_addr_i = 6'h00;
    logic reg_wr_i = 1'b0;
    logic [3:0] reg_be_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h00000000;
    logic reg_rd_i = 1'b0;
    logic [31:0] reg_rdata_o;
    logic [3:0] run = 4'h0;
    logic [3:0] frm;
    logic [2:0] en = 3'h0;
    logic [2:0] step = 3'h1;
    logic p1_adv, p1_rep, p1_zero, p2_adv, p2_rep, p2_zero, rec_cap, rec_act, rec_zero;
    logic [15:0] p2_addr;
    logic [31:0] q_rd[$];
    logic [31:0] q_ad[$];
    int n_errors = 0;
    int checks = 0;
    logic p1 = 1'b0;
    logic p2 = 1'b0;
    logic pa = 1'b0;
    logic ad_on = 1'b0;
    int ncap = 0;
    logic [2:0] zs;
    assign zs = {rec_zero, p2_zero, p1_zero};
    always #10 sys_clk_i = ~sys_clk_i;
    scc_codec_model u_codec (.run_i(run), .frame_o(frm));
    scc_top uut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_be_i(reg_be_i), .reg_wdata_i(reg_wdata_i),
        .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .play1_frame_i(frm[0]),
        .play2_frame_i(frm[1]), .rec_frame_i(frm[2]), .serial_in_frame_i(frm[3]),
        .play1_en_i(en[0]), .play2_en_i(en[1]), .rec_en_i(en[2]), .play2_step_i(step),
        .play1_advance_o(p1_adv), .play1_repeat_o(p1_rep), .play1_zero_o(p1_zero),
        .play2_advance_o(p2_adv), .play2_repeat_o(p2_rep), .play2_zero_o(p2_zero),
        .play2_addr_o(p2_addr), .rec_capture_o(rec_cap), .rec_active_o(rec_act),
        .rec_zero_o(rec_zero));
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s exp %h got %h", nm, exp, got);
        end
    endtask
    task tally_and_finish;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task wr(input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
        reg_addr_i = a;
        reg_be_i = b;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        cyc(1);
        reg_wr_i = 1'b0;
    endtask
    task rd(input logic [5:0] a, input logic [31:0] e);
        q_rd.push_back(e);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        cyc(1);
        reg_rd_i = 1'b0;
        cyc(2);
    endtask
    // Returns one cycle after the expiry pulse, before the next frame edge
    task wz(input int s);
        int k;
        k = 0;
        while (zs[s] !== 1'b1 && k < 400) begin
            cyc(1);
            k++;
        end
        if (k == 400) begin
            n_errors++;
            tally_and_finish();
        end else begin
            cyc(1);
        end
    endtask
    // Read data lands one cycle after the strobe; address settles after advance
    always @(negedge sys_clk_i) begin
        if (p2) begin
            chk("rdata", reg_rdata_o, q_rd.pop_front());
        end
        if (rec_cap) begin
            ncap++;
        end
        // Addresses are only predicted during the loop scenario
        if (pa && ad_on) begin
            chk("p2 addr", {16'h0000, p2_addr},
                q_ad.size() > 0 ? q_ad.pop_front() : 32'hFFFFFFFF);
        end
        p2 = p1;
        p1 = reg_rd_i;
        pa = p2_adv;
    end
    initial begin
        logic [31:0] r;
        logic [2:0] so;
        logic [2:0] eo;
        logic [15:0] a;
        r = $urandom(32'h95f8519d);
        cyc(4);
        nrst_i = 1'b1;
        rd(SCC_CTRL_OFS, SCC_CTRL_RST);
        rd(SCC_PLAY1_CNT_OFS, 32'h00000000);
        rd(SCC_PLAY2_CNT_OFS, 32'h00000000);
        rd(SCC_REC_CNT_OFS, 32'h00000000);
        rd(6'h30, 32'h00000000);
        r = $urandom;
        wr(SCC_CTRL_OFS, 4'hF, r);
        rd(SCC_CTRL_OFS, {SCC_CTRL_ONES, r[22:0]});
        wr(SCC_CTRL_OFS, 4'h2, ~r);
        rd(SCC_CTRL_OFS, {SCC_CTRL_ONES, r[22:16], ~r[15:8], r[7:0]});
        wr(SCC_PLAY1_CNT_OFS, 4'hF, {16'hFFFF, r[15:0]});
        rd(SCC_PLAY1_CNT_OFS, {16'h0000, r[15:0]});
        $display("test registers done");
        so = 3'($urandom) & 3'h6;
        eo = 3'($urandom % 7) + 3'h1;
        step = 3'($urandom % 7) + 3'h1;
        wr(SCC_CTRL_OFS, 4'hF, {9'h000, eo, so, 16'h0000});
        wr(SCC_PLAY2_CNT_OFS, 4'h3, 32'h00000001);
        a = 16'(so);
        // Loop of two samples: step, then loop-end offset on the expiry sample
        for (int i = 0; i < 4; i++) begin
            a = a + 16'(i[0] ? eo : step);
            q_ad.push_back({16'h0000, a});
        end
        en[1] = 1'b1;
        cyc(2);
        rd(SCC_PLAY2_CNT_OFS, 32'h00010001);
        ad_on = 1'b1;
        run = 4'h2;
        wz(1);
        wz(1);
        run = 4'h0;
        en[1] = 1'b0;
        // The last address is compared at the second falling edge after its pulse
        cyc(1);
        chk("addr queue", 32'(q_ad.size()), 32'h0);
        ad_on = 1'b0;
        $display("test play2 loop done");
        wr(SCC_CTRL_OFS, 4'hF, 32'h00004000);
        wr(SCC_PLAY2_CNT_OFS, 4'h3, 32'h00000000);
        en[1] = 1'b1;
        run = 4'h2;
        wz(1);
        cyc(3);
        chk("p2 repeat", 32'(p2_rep), 32'h1);
        rd(SCC_PLAY2_CNT_OFS, 32'h00000000);
        run = 4'h0;
        en[1] = 1'b0;
        $display("test play2 stop done");
        wr(SCC_CTRL_OFS, 4'hF, 32'h00001800);
        wr(SCC_PLAY1_CNT_OFS, 4'h3, 32'h00000003);
        en = 3'b011;
        run = 4'h3;
        cyc(40);
        chk("p1 repeat", 32'(p1_rep), 32'h1);
        chk("p2 repeat", 32'(p2_rep), 32'h1);
        rd(SCC_PLAY1_CNT_OFS, 32'h00030003);
        en[1] = 1'b0;
        wr(SCC_CTRL_OFS, 4'h2, 32'h00000000);
        wz(0);
        chk("p1 repeat", 32'(p1_rep), 32'h0);
        run = 4'h0;
        en = 3'b000;
        $display("test hold done");
        wr(SCC_CTRL_OFS, 4'hF, 32'h00408000);
        wr(SCC_REC_CNT_OFS, 4'h3, 32'h00000001);
        en[2] = 1'b1;
        run = 4'h8;
        wz(2);
        cyc(3);
        chk("rec active", 32'(rec_act), 32'h0);
        chk("rec captures", 32'(ncap), 32'h2);
        en[2] = 1'b0;
        wr(SCC_CTRL_OFS, 4'h2, 32'h00000000);
        en[2] = 1'b1;
        wz(2);
        cyc(1);
        chk("rec active", 32'(rec_act), 32'h1);
        $display("test record done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
